// file: hw/ext_irq_pkg.sv
package ext_irq_pkg;

  localparam int CLK_PERIOD_NS = 40;
  // Least pulse width on the third line, rounded up to whole cycles
  localparam int T_INT_NS = 50;
  localparam int INT_PULSE_CYC = (T_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC = 16;

  localparam logic [4:0] SENSE_OFS = 5'h00;
  localparam logic [4:0] CSR_OFS = 5'h04;
  localparam logic [4:0] MASK_OFS = 5'h08;
  localparam logic [4:0] FLAG_OFS = 5'h0C;
  localparam logic [4:0] CPU_STAT_OFS = 5'h10;

  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] PIN_IDLE = 4'h7;

  localparam int LINE_ONE_BIT = 7;
  localparam int LINE_ZERO_BIT = 6;
  localparam int LINE_TWO_BIT = 5;
  localparam int EDGE_SEL_BIT = 6;
  localparam int GIE_BIT = 7;

  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_ANY = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } sense_t;

  typedef struct packed {
    logic sm2;
    logic sleep_en;
    logic sm1;
    logic sm0;
    sense_t line_one_sense;
    sense_t line_zero_sense;
  } sense_ctrl_t;

  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_ASLEEP,
    PWR_STARTUP
  } pwr_state_t;

endpackage : ext_irq_pkg

// file: hw/external_pin_interrupts.sv
// Function
// - Pin activity requests even when driven as output
// - Third line is edge only, no level
// - Level mode requests while pin stays low
// - Lines zero/one edges need running I/O clock
// - Level and third-line edges work while asleep
// - Level wake needs two watchdog samples low
// - Level gone after startup: wake, no request
// - Request needs global enable and line mask
// - Pins sampled first; pulses over two clocks caught
// - Line one sense in control bits 3:2
// - Line zero sense in control bits 1:0
// - Status bit 6 picks third-line edge
// - Third-line edges over 80 ns (two clocks) give request
// - Flag set on trigger, cleared vector/write-one
// - Mask bits 7, 6, 5 for lines one/zero/two
`timescale 1ns/1ps
`default_nettype none

module external_pin_interrupts (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] ext_irq_pin,
  input wire logic wdt_osc_clk,
  input wire logic sleep_cmd,
  input wire logic [2:0] irq_ack,
  output logic irq,
  output logic [2:0] irq_req,
  output logic io_clk_run,
  output logic cpu_awake,
  output logic wake_pulse
);

  // Internal line order: [0] zero, [1] one, [2] two
  function automatic logic [7:0] to_reg(input logic [2:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[ext_irq_pkg::LINE_ONE_BIT] = v[1];
    r[ext_irq_pkg::LINE_ZERO_BIT] = v[0];
    r[ext_irq_pkg::LINE_TWO_BIT] = v[2];
    return r;
  endfunction : to_reg

  function automatic logic [2:0] from_reg(input logic [7:0] r);
    return {r[ext_irq_pkg::LINE_TWO_BIT], r[ext_irq_pkg::LINE_ONE_BIT],
            r[ext_irq_pkg::LINE_ZERO_BIT]};
  endfunction : from_reg

  function automatic logic edge_hit(input ext_irq_pkg::sense_t s, input logic r,
                                    input logic f);
    case (s)
      ext_irq_pkg::SENSE_ANY: return r | f;
      ext_irq_pkg::SENSE_FALL: return f;
      ext_irq_pkg::SENSE_RISE: return r;
      default: return 1'h0;
    endcase
  endfunction : edge_hit

  ext_irq_pkg::sense_ctrl_t sense_ff;
  ext_irq_pkg::pwr_state_t state_ff;
  logic edge_sel_ff;
  logic gie_ff;
  logic [2:0] mask_ff;
  logic [2:0] flag_ff;
  logic [2:0] nxt_flag;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic [3:0] filt_ff;
  logic [3:0] prev_ff;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [1:0] low_seen_ff;
  logic [4:0] start_cnt_ff;
  logic done_ff;
  logic bus_req;
  logic wr_fire;
  logic [2:0] w1c;
  logic [2:0] ev;
  logic [1:0] lvl_mode;
  logic [1:0] lvl_req;
  logic [2:0] req;
  logic idle_mode;
  logic wdt_tick;
  logic lvl_wake;
  logic wake_cond;
  logic [7:0] rd_val;

  // Pins are read whatever their direction, so a driven pin still requests
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_ff <= ext_irq_pkg::PIN_IDLE;
      sync2_ff <= ext_irq_pkg::PIN_IDLE;
      sync3_ff <= ext_irq_pkg::PIN_IDLE;
    end else begin
      sync1_ff <= {wdt_osc_clk, ext_irq_pin};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A level is taken only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      filt_ff <= ext_irq_pkg::PIN_IDLE;
      prev_ff <= ext_irq_pkg::PIN_IDLE;
    end else begin
      filt_ff <= (~(sync2_ff ^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & filt_ff);
      prev_ff <= filt_ff;
    end
  end

  assign rise = filt_ff & ~prev_ff;
  assign fall = ~filt_ff & prev_ff;
  assign wdt_tick = rise[3];

  assign idle_mode = ({sense_ff.sm2, sense_ff.sm1, sense_ff.sm0} == 3'h0);
  assign io_clk_run = (state_ff == ext_irq_pkg::PWR_AWAKE) ||
                      ((state_ff == ext_irq_pkg::PWR_ASLEEP) && idle_mode);
  assign cpu_awake = (state_ff == ext_irq_pkg::PWR_AWAKE);

  assign lvl_mode[0] = (sense_ff.line_zero_sense == ext_irq_pkg::SENSE_LOW);
  assign lvl_mode[1] = (sense_ff.line_one_sense == ext_irq_pkg::SENSE_LOW);

  // Edges on lines zero/one only while the I/O clock runs
  assign ev[0] = io_clk_run && edge_hit(sense_ff.line_zero_sense, rise[0], fall[0]);
  assign ev[1] = io_clk_run && edge_hit(sense_ff.line_one_sense, rise[1], fall[1]);
  // Third line: edge only, caught in any power state
  assign ev[2] = edge_sel_ff ? rise[2] : fall[2];

  // Level request holds while low; suppressed until startup ends
  assign lvl_req = lvl_mode & ~filt_ff[1:0] & {2{cpu_awake}};

  // Global enable and line mask both gate the request
  assign req = (flag_ff | {1'h0, lvl_req}) & mask_ff & {3{gie_ff}};
  assign irq_req = req;
  assign irq = |req;

  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !done_ff;
  assign wr_fire = avs_write && done_ff && avs_byteenable[0];
  assign w1c = (wr_fire && (avs_address == ext_irq_pkg::FLAG_OFS)) ?
               from_reg(avs_writedata[7:0]) : 3'h0;

  // Set wins over clear; level-mode flags always read cleared
  always_comb begin
    nxt_flag = (flag_ff & ~(w1c | irq_ack)) | ev;
    nxt_flag[1:0] = nxt_flag[1:0] & ~lvl_mode;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_ff <= 3'h0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sense_ff <= ext_irq_pkg::sense_ctrl_t'(ext_irq_pkg::SENSE_RST);
      edge_sel_ff <= 1'h0;
      mask_ff <= 3'h0;
      gie_ff <= 1'h0;
    end else if (wr_fire) begin
      case (avs_address)
        ext_irq_pkg::SENSE_OFS: begin
          sense_ff <= ext_irq_pkg::sense_ctrl_t'(avs_writedata[7:0]);
        end
        ext_irq_pkg::CSR_OFS: begin
          edge_sel_ff <= avs_writedata[ext_irq_pkg::EDGE_SEL_BIT];
        end
        ext_irq_pkg::MASK_OFS: begin
          mask_ff <= from_reg(avs_writedata[7:0]);
        end
        ext_irq_pkg::CPU_STAT_OFS: begin
          gie_ff <= avs_writedata[ext_irq_pkg::GIE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rd_val = ext_irq_pkg::REG_RST;
    case (avs_address)
      ext_irq_pkg::SENSE_OFS: rd_val = sense_ff;
      ext_irq_pkg::CSR_OFS: rd_val[ext_irq_pkg::EDGE_SEL_BIT] = edge_sel_ff;
      ext_irq_pkg::MASK_OFS: rd_val = to_reg(mask_ff);
      ext_irq_pkg::FLAG_OFS: rd_val = to_reg(flag_ff);
      ext_irq_pkg::CPU_STAT_OFS: rd_val[ext_irq_pkg::GIE_BIT] = gie_ff;
      default: rd_val = ext_irq_pkg::REG_RST;
    endcase
  end

  // Fixed one wait state keeps the read mux off the bus path
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_ff <= 1'h0;
      avs_readdata <= 32'h0;
    end else begin
      done_ff <= bus_req && !done_ff;
      if (avs_read && !done_ff) begin
        avs_readdata <= {24'h0, rd_val};
      end
    end
  end

  // Two consecutive watchdog samples low before wake-up starts
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      low_seen_ff <= 2'h0;
    end else if (state_ff != ext_irq_pkg::PWR_ASLEEP) begin
      low_seen_ff <= 2'h0;
    end else if (wdt_tick) begin
      low_seen_ff <= lvl_mode & ~filt_ff[1:0];
    end
  end

  assign lvl_wake = wdt_tick &&
                    |(low_seen_ff & lvl_mode & ~filt_ff[1:0] & mask_ff[1:0]) && gie_ff;
  assign wake_cond = lvl_wake || (ev[2] && mask_ff[2] && gie_ff) ||
                     (idle_mode && |(flag_ff & mask_ff) && gie_ff);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ext_irq_pkg::PWR_AWAKE;
      start_cnt_ff <= 5'h00;
      wake_pulse <= 1'h0;
    end else begin
      wake_pulse <= 1'h0;
      case (state_ff)
        ext_irq_pkg::PWR_AWAKE: begin
          if (sleep_cmd && sense_ff.sleep_en) begin
            state_ff <= ext_irq_pkg::PWR_ASLEEP;
          end
        end
        ext_irq_pkg::PWR_ASLEEP: begin
          if (wake_cond) begin
            state_ff <= ext_irq_pkg::PWR_STARTUP;
            start_cnt_ff <= 5'h00;
          end
        end
        ext_irq_pkg::PWR_STARTUP: begin
          // Level is judged again only once awake
          if (start_cnt_ff == 5'(ext_irq_pkg::STARTUP_CYC - 1)) begin
            state_ff <= ext_irq_pkg::PWR_AWAKE;
            wake_pulse <= 1'h1;
          end else begin
            start_cnt_ff <= start_cnt_ff + 5'h01;
          end
        end
        default: begin
          state_ff <= ext_irq_pkg::PWR_AWAKE;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_level_holds_req: assert property (
    (lvl_mode[0] && !filt_ff[0] && cpu_awake && mask_ff[0] && gie_ff) |-> irq)
    else $error("level request missing while pin low");
  a_level_flag_zero: assert property (lvl_mode[1] |=> !flag_ff[1])
    else $error("flag set in level mode");
  a_gate_by_enable: assert property (irq |-> gie_ff && (|mask_ff))
    else $error("request without enable and mask");
  a_edge_sets_flag: assert property (
    (io_clk_run && sense_ff.line_zero_sense == ext_irq_pkg::SENSE_RISE
     && $rose(filt_ff[0])) |=> flag_ff[0])
    else $error("rising edge on line zero not flagged");
  a_io_clk_gate: assert property (
    !io_clk_run |=> ((flag_ff[1:0] & ~$past(flag_ff[1:0])) == 2'h0))
    else $error("sync edge flagged without I/O clock");
  a_line_two_async: assert property (
    (!edge_sel_ff && fall[2]) |=> flag_ff[2])
    else $error("third line edge lost");
  a_line_two_edge: assert property (
    !ev[2] |=> !(flag_ff[2] && !$past(flag_ff[2])))
    else $error("third line flag set without edge");
  a_wake_on_sample: assert property (
    (state_ff == ext_irq_pkg::PWR_ASLEEP && lvl_wake)
    |=> state_ff == ext_irq_pkg::PWR_STARTUP)
    else $error("no startup after two low samples");
  a_no_stale_level: assert property (
    (wake_pulse && (lvl_mode & ~filt_ff[1:0]) == 2'h0 && flag_ff == 3'h0) |-> !irq)
    else $error("request after level vanished");
  a_bus_one_wait: assert property ((bus_req && !done_ff) |=> !avs_waitrequest)
    else $error("bus answer late");

  c_edge_irq: cover property (ev[0] ##1 irq);
  c_level_irq: cover property (lvl_req[1] && irq);
  c_wake_up: cover property (state_ff == ext_irq_pkg::PWR_STARTUP ##1 wake_pulse);
  c_flag_clear: cover property (flag_ff[2] ##1 !flag_ff[2]);

endmodule : external_pin_interrupts

`default_nettype wire

// file: tb/pin_source.sv
`timescale 1ns/1ps
`default_nettype none

module pin_source (
  input wire logic ref_clk,
  input wire logic [2:0] want,
  output logic [2:0] pins,
  output logic wdt_clk
);
  // Free running and unrelated to ref_clk, as the real oscillator is
  always begin
    wdt_clk = 1'b0;
    #170;
    wdt_clk = 1'b1;
    #170;
  end

  // Whole-cycle levels, so every pulse lasts at least one clock
  always @(posedge ref_clk) begin
    pins <= want;
  end
endmodule : pin_source

`default_nettype wire

// file: tb/external_pin_interrupts_bench.sv
`timescale 1ns/1ps
`default_nettype none

module external_pin_interrupts_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, wdt_osc_clk, irq, io_clk_run, cpu_awake, wake_pulse;
  logic sleep_cmd = 1'b0;
  logic [2:0] irq_ack = 3'h0;
  logic [2:0] irq_req, ext_irq_pin;
  logic [2:0] want = 3'h7;
  logic [31:0] q;
  logic [6:0] r;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int i;
  // Flag expected, line, mode or edge select, start level, end level
  logic [6:0] rows [11] = '{7'h4A, 7'h09, 7'h4D, 7'h0E, 7'h46, 7'h55,
                           7'h5A, 7'h5D, 7'h62, 7'h65, 7'h26};

  external_pin_interrupts external_pin_interrupts_inst (.ref_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .ext_irq_pin, .wdt_osc_clk, .sleep_cmd, .irq_ack, .irq,
    .irq_req, .io_clk_run, .cpu_awake, .wake_pulse);
  pin_source pin_source_inst (.ref_clk, .want, .pins(ext_irq_pin), .wdt_clk(wdt_osc_clk));

  always #20 ref_clk = ~ref_clk;

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t ns: seen %0h, expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      bus(5'(i * 4), 1'b0, 8'h00);
      chk(q, 32'h0);
    end
    avs_byteenable <= 4'h0;
    bus(ext_irq_pkg::CSR_OFS, 1'b1, 8'h40);
    avs_byteenable <= 4'hF;
    bus(5'h14, 1'b1, 8'hFF);
    bus(ext_irq_pkg::CSR_OFS, 1'b0, 8'h00);
    chk(q, 32'h0);
    bus(5'h14, 1'b0, 8'h00);
    chk(q, 32'h0);
    bus(ext_irq_pkg::SENSE_OFS, 1'b1, 8'h0F);
    bus(ext_irq_pkg::SENSE_OFS, 1'b0, 8'h00);
    chk(q, 32'h0F);
    $display("Register test done");
    bus(ext_irq_pkg::CPU_STAT_OFS, 1'b1, 8'h80);
    for (i = 0; i < 11; i++) begin
      r = rows[i];
      // Mask off, select, clear, re-enable: avoids a spurious request
      bus(ext_irq_pkg::MASK_OFS, 1'b1, 8'h00);
      if (r[5:4] == 2'h2) bus(ext_irq_pkg::CSR_OFS, 1'b1, {1'b0, r[2], 6'h0});
      else bus(ext_irq_pkg::SENSE_OFS, 1'b1, 8'(r[3:2]) << (2 * r[5:4]));
      want <= 3'h7 & ~(3'(!r[1]) << r[5:4]);
      tick(8);
      bus(ext_irq_pkg::FLAG_OFS, 1'b1, 8'hE0);
      bus(ext_irq_pkg::MASK_OFS, 1'b1, 8'hE0);
      want <= 3'h7 & ~(3'(!r[0]) << r[5:4]);
      tick(8);
      @(negedge ref_clk);
      chk(32'(irq), 32'(r[6]));
      bus(ext_irq_pkg::FLAG_OFS, 1'b0, 8'h00);
      chk(q, 32'(r[6]) << ((r[5:4] == 2'h2) ? 5 : 6 + r[5:4]));
    end
    $display("Sense table done");
    bus(ext_irq_pkg::CPU_STAT_OFS, 1'b1, 8'h00);
    bus(ext_irq_pkg::SENSE_OFS, 1'b1, 8'h02);
    want <= 3'h7;
    tick(8);
    bus(ext_irq_pkg::FLAG_OFS, 1'b1, 8'hE0);
    want <= 3'h6;
    tick(8);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0);
    bus(ext_irq_pkg::FLAG_OFS, 1'b0, 8'h00);
    chk(q, 32'h40);
    bus(ext_irq_pkg::CPU_STAT_OFS, 1'b1, 8'h80);
    @(negedge ref_clk);
    chk(32'(irq_req), 32'h1);
    @(posedge ref_clk);
    irq_ack <= 3'h1;
    @(posedge ref_clk);
    irq_ack <= 3'h0;
    @(negedge ref_clk);
    chk(32'(irq), 32'h0);
    $display("Mask and acknowledge test done");
    bus(ext_irq_pkg::SENSE_OFS, 1'b1, 8'h00);
    want <= 3'h5;
    tick(8);
    bus(ext_irq_pkg::FLAG_OFS, 1'b1, 8'hE0);
    tick(20);
    @(negedge ref_clk);
    chk(32'(irq_req), 32'h2);
    bus(ext_irq_pkg::FLAG_OFS, 1'b0, 8'h00);
    chk(q, 32'h0);
    want <= 3'h7;
    tick(8);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0);
    $display("Level test done");
    bus(ext_irq_pkg::SENSE_OFS, 1'b1, 8'h60);
    sleep_cmd <= 1'b1;
    @(posedge ref_clk);
    sleep_cmd <= 1'b0;
    tick(2);
    @(negedge ref_clk);
    chk({io_clk_run, cpu_awake}, 32'h0);
    @(posedge ref_clk);
    want <= 3'h5;
    for (i = 0; i < 300 && wake_pulse !== 1'b1; i++) @(negedge ref_clk);
    chk(32'(wake_pulse), 32'h1);
    tick(1);
    @(negedge ref_clk);
    chk({cpu_awake, irq_req}, 32'hA);
    $display("Sleep test done");
    tick(1);
    want <= 3'h7;
    tick(8);
    sleep_cmd <= 1'b1;
    tick(1);
    sleep_cmd <= 1'b0;
    want <= 3'h5;
    // Low past both watchdog samples, gone well before startup ends
    tick(22);
    want <= 3'h7;
    for (i = 0; i < 300 && wake_pulse !== 1'b1; i++) @(negedge ref_clk);
    chk({wake_pulse, irq}, 32'h2);
    $display("Vanished level test done");
    tick(1);
    sleep_cmd <= 1'b1;
    tick(1);
    sleep_cmd <= 1'b0;
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    bus(ext_irq_pkg::SENSE_OFS, 1'b0, 8'h00);
    chk(q, 32'(ext_irq_pkg::SENSE_RST));
    @(negedge ref_clk);
    chk({irq, io_clk_run, cpu_awake, wake_pulse}, 32'h6);
    $display("Reset test done");
    end_sim();
  end
endmodule : external_pin_interrupts_bench

`default_nettype wire
